// file: rtl/mpio_pkg.sv
package mpio_pkg;

   // ----------------------------------------------------------------
   // register map: word index, byte address is four times the index
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [6:0] IDX_PORT0_OUT_LATCH = 7'h00;
   localparam logic [6:0] IDX_PORT1_OUT_LATCH = 7'h01;
   localparam logic [6:0] IDX_PORT2_OUT_LATCH = 7'h02;
   localparam logic [6:0] IDX_PORT3_OUT_LATCH = 7'h03;
   localparam logic [6:0] IDX_PORT4_OUT_LATCH = 7'h04;
   localparam logic [6:0] IDX_PORT0_DIR = 7'h08;
   localparam logic [6:0] IDX_PORT1_DIR = 7'h09;
   localparam logic [6:0] IDX_PORT3_DIR = 7'h0a;
   localparam logic [6:0] IDX_PORT4_DIR = 7'h0b;
   localparam logic [6:0] IDX_PORT4_OPEN_DRAIN_SEL = 7'h0c;
   localparam logic [6:0] IDX_PORT2_PIN_IN = 7'h0d;
   localparam logic [6:0] IDX_PORT4_PIN_IN = 7'h0e;
   localparam logic [6:0] IDX_EXT_BUS_CTRL = 7'h31;
   localparam logic [6:0] IDX_BUS_STALL_CTRL = 7'h32;
   localparam logic [6:0] IDX_PORT_MODE_CTRL = 7'h40;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PORT0_OUT_LATCH = 8'h00;
   localparam logic [7:0] RST_PORT1_OUT_LATCH = 8'h00;
   localparam logic [7:0] RST_PORT2_OUT_LATCH = 8'hff;
   localparam logic [7:0] RST_PORT3_OUT_LATCH = 8'h00;
   localparam logic [7:0] RST_PORT4_OUT_LATCH = 8'hff;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PORT4_OPEN_DRAIN_SEL = 8'h00;
   localparam logic [7:0] RST_EXT_BUS_CTRL = 8'h00;
   localparam logic [7:0] RST_BUS_STALL_CTRL = 8'h00;
   localparam logic [2:0] RST_PORT_MODE_CTRL = 3'h1;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned EXT_WRITE_STROBE_OUT_EN_BIT = 0;
   localparam int unsigned EXT_READ_STROBE_OUT_EN_BIT = 1;
   localparam int unsigned EXT_HIGH_ADDR_BUS_EN_BIT = 2;
   localparam int unsigned STALL_CTRL_HI_BIT = 7;
   localparam int unsigned STALL_CTRL_LO_BIT = 6;
   localparam int unsigned MODE_GLOBAL_PIN_DRIVE_EN_BIT = 0;
   localparam int unsigned MODE_STOP_BIT = 1;
   localparam int unsigned MODE_DUAL_CLOCK_BIT = 2;
   localparam int unsigned MODE_CLOCK_OUT_ACTIVE_BIT = 3;
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] p4;
      logic [7:0] p3;
      logic [2:0] p2;
      logic [7:0] p1;
      logic [7:0] p0;
   } mpio_pins_t;

   typedef struct packed {
      logic access;
      logic ale;
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mpio_ext_bus_t;

   typedef struct packed {
      logic divider_out;
      logic timer_out_zero;
      logic timer_out_one;
      logic compare_out_zero;
   } mpio_alt_out_t;

endpackage

// file: rtl/mpio_ports.sv
`timescale 1ns/100ps
// What this block does
// - output pins driven from stored latch; inputs read live pin level
// - pin level for a read is sampled in the read's setup cycle
// - written output value reaches pins in the second cycle after write
// - port 0 per-bit direction; reset gives all inputs, latch zero
// - port 0 becomes multiplexed address/data bus during external access
// - port 1 per-bit direction; reset gives all inputs, latch zero
// - port 1 bits 5,6 give write/read strobes; bit 7 address latch enable
// - access select pin low at reset release: clock pulse on port 1 bit 0
// - port 2 bits 1,2 crystal pins in dual-clock mode, else I/O
// - falling edge on port 2 bit 0, even self driven, flags interrupt
// - port 2 pin read gives no meaningful data in bits 7 to 3
// - ports 2 and 4 keep latch and pin view at separate addresses
// - ports 0,1,3 read pin level for input bits, latch for outputs
// - stop mode floats port 2 bit 0 whatever the global drive enable
// - port 3 resets to inputs, latch zero; drives high address byte
// - port 4 resets to inputs with latch all ones; dir one drives
// - port 4 open-drain select per bit, zero push-pull, reset zero
module mpio_ports
   import mpio_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire mpio_pins_t PIN_IN_I,
   output mpio_pins_t PIN_OUT_O,
   output mpio_pins_t PIN_OE_O,
   input wire logic EXT_ACCESS_SEL_PIN_N_I,
   input wire logic MCYCLE_I,
   input wire mpio_ext_bus_t EXT_BUS_I,
   input wire mpio_alt_out_t ALT_OUT_I,
   output logic [7:0] EXT_RDATA_O,
   output logic BUS_STALL_N_O,
   output logic PORT2_BIT0_FALL_O,
   output mpio_pins_t PIN_LEVEL_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] port0_out_latch;
   logic [7:0] port1_out_latch;
   logic [7:0] port2_out_latch;
   logic [7:0] port3_out_latch;
   logic [7:0] port4_out_latch;
   logic [7:0] port0_dir;
   logic [7:0] port1_dir;
   logic [7:0] port3_dir;
   logic [7:0] port4_dir;
   logic [7:0] port4_open_drain_sel;
   logic [7:0] ext_bus_ctrl;
   logic [7:0] bus_stall_ctrl;
   logic [2:0] mode_ctrl;
   logic clock_out_active;
   logic [1:0] strap_cnt;
   logic strap_done;
   mpio_pins_t pin_meta;
   mpio_pins_t pin_sync;
   logic ea_meta;
   logic ea_sync;
   logic p20_prev;
   mpio_pins_t next_out;
   mpio_pins_t next_oe;
   logic [6:0] reg_idx;
   logic hit;
   logic writable;
   logic [7:0] next_rdata;
   logic wr_en;
   logic rd_en;
   logic hi_en;
   logic stall_en;
   logic drive_en;
   logic stop_mode;
   logic dual_clock;

   assign wr_en = ext_bus_ctrl[EXT_WRITE_STROBE_OUT_EN_BIT];
   assign rd_en = ext_bus_ctrl[EXT_READ_STROBE_OUT_EN_BIT];
   assign hi_en = ext_bus_ctrl[EXT_HIGH_ADDR_BUS_EN_BIT];
   assign stall_en = bus_stall_ctrl[STALL_CTRL_HI_BIT] | bus_stall_ctrl[STALL_CTRL_LO_BIT];
   assign drive_en = mode_ctrl[MODE_GLOBAL_PIN_DRIVE_EN_BIT];
   assign stop_mode = mode_ctrl[MODE_STOP_BIT];
   assign dual_clock = mode_ctrl[MODE_DUAL_CLOCK_BIT];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         ea_meta <= 1'b1;
         ea_sync <= 1'b1;
      end
      else
      begin
         pin_meta <= PIN_IN_I;
         pin_sync <= pin_meta;
         ea_meta <= EXT_ACCESS_SEL_PIN_N_I;
         ea_sync <= ea_meta;
      end
   end

   // ----------------------------------------------------------------
   // access select strap, caught once after reset release
   // ----------------------------------------------------------------
   // wait for the synchroniser to fill before trusting the strap
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
         clock_out_active <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == STRAP_SETTLE_CYCLES)
         begin
            strap_done <= 1'b1;
            clock_out_active <= ~ea_sync;
         end
      end
   end

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign reg_idx = PADDR_I[8:2];

   always_comb
   begin
      hit = (PADDR_I[1:0] == 2'h0) && (PADDR_I[ADDR_W-1:9] == '0);
      writable = 1'b1;
      next_rdata = 8'h00;
      unique case (reg_idx)
         // pin level for input bits, latch for output bits
         IDX_PORT0_OUT_LATCH: next_rdata = (port0_dir & port0_out_latch)
                                          | (~port0_dir & pin_sync.p0);
         IDX_PORT1_OUT_LATCH: next_rdata = (port1_dir & port1_out_latch)
                                          | (~port1_dir & pin_sync.p1);
         IDX_PORT3_OUT_LATCH: next_rdata = (port3_dir & port3_out_latch)
                                          | (~port3_dir & pin_sync.p3);
         IDX_PORT2_OUT_LATCH: next_rdata = port2_out_latch;
         IDX_PORT4_OUT_LATCH: next_rdata = port4_out_latch;
         IDX_PORT0_DIR: next_rdata = port0_dir;
         IDX_PORT1_DIR: next_rdata = port1_dir;
         IDX_PORT3_DIR: next_rdata = port3_dir;
         IDX_PORT4_DIR: next_rdata = port4_dir;
         IDX_PORT4_OPEN_DRAIN_SEL: next_rdata = port4_open_drain_sel;
         IDX_PORT2_PIN_IN:
         begin
            next_rdata = {5'h00, pin_sync.p2};
            writable = 1'b0;
         end
         IDX_PORT4_PIN_IN:
         begin
            next_rdata = pin_sync.p4;
            writable = 1'b0;
         end
         IDX_EXT_BUS_CTRL: next_rdata = ext_bus_ctrl;
         IDX_BUS_STALL_CTRL: next_rdata = bus_stall_ctrl;
         IDX_PORT_MODE_CTRL: next_rdata = {4'h0, clock_out_active, mode_ctrl};
         default: hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // apb answer: data caught in the setup cycle, ready in access
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
      else if (PSEL_I && !PENABLE_I)
      begin
         PRDATA_O <= (hit && !PWRITE_I) ? {24'h000000, next_rdata} : 32'h0000_0000;
         PREADY_O <= 1'b1;
         PSLVERR_O <= ~hit | (PWRITE_I & ~writable);
      end
      else
      begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   logic do_write;
   assign do_write = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & hit & writable;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         port0_out_latch <= RST_PORT0_OUT_LATCH;
         port1_out_latch <= RST_PORT1_OUT_LATCH;
         port2_out_latch <= RST_PORT2_OUT_LATCH;
         port3_out_latch <= RST_PORT3_OUT_LATCH;
         port4_out_latch <= RST_PORT4_OUT_LATCH;
      end
      else if (do_write)
      begin
         unique case (reg_idx)
            IDX_PORT0_OUT_LATCH: port0_out_latch <= PWDATA_I[7:0];
            IDX_PORT1_OUT_LATCH: port1_out_latch <= PWDATA_I[7:0];
            IDX_PORT2_OUT_LATCH: port2_out_latch <= PWDATA_I[7:0];
            IDX_PORT3_OUT_LATCH: port3_out_latch <= PWDATA_I[7:0];
            IDX_PORT4_OUT_LATCH: port4_out_latch <= PWDATA_I[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         port0_dir <= RST_DIR;
         port1_dir <= RST_DIR;
         port3_dir <= RST_DIR;
         port4_dir <= RST_DIR;
         port4_open_drain_sel <= RST_PORT4_OPEN_DRAIN_SEL;
         ext_bus_ctrl <= RST_EXT_BUS_CTRL;
         bus_stall_ctrl <= RST_BUS_STALL_CTRL;
         mode_ctrl <= RST_PORT_MODE_CTRL;
      end
      else if (do_write)
      begin
         unique case (reg_idx)
            IDX_PORT0_DIR: port0_dir <= PWDATA_I[7:0];
            IDX_PORT1_DIR: port1_dir <= PWDATA_I[7:0];
            IDX_PORT3_DIR: port3_dir <= PWDATA_I[7:0];
            IDX_PORT4_DIR: port4_dir <= PWDATA_I[7:0];
            IDX_PORT4_OPEN_DRAIN_SEL: port4_open_drain_sel <= PWDATA_I[7:0];
            IDX_EXT_BUS_CTRL: ext_bus_ctrl <= PWDATA_I[7:0];
            IDX_BUS_STALL_CTRL: bus_stall_ctrl <= PWDATA_I[7:0];
            IDX_PORT_MODE_CTRL: mode_ctrl <= PWDATA_I[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   always_comb
   begin
      next_out.p0 = port0_out_latch;
      next_oe.p0 = port0_dir;
      if (EXT_BUS_I.access)
      begin
         // address while latch enable is high, then write data or float
         next_out.p0 = EXT_BUS_I.ale ? EXT_BUS_I.addr[7:0] : EXT_BUS_I.wdata;
         next_oe.p0 = {8{EXT_BUS_I.ale | ~EXT_BUS_I.rd}};
      end

      next_out.p1 = port1_out_latch;
      next_oe.p1 = port1_dir;
      // alternate outputs only pass while the latch holds one
      next_out.p1[3] = port1_out_latch[3] & ALT_OUT_I.divider_out;
      next_out.p1[4] = port1_out_latch[4] & ALT_OUT_I.timer_out_one;
      if (stall_en)
      begin
         next_oe.p1[1] = 1'b0;
      end
      if (clock_out_active)
      begin
         next_out.p1[0] = ~MCYCLE_I;
         next_oe.p1[0] = 1'b1;
      end
      if (EXT_BUS_I.access && wr_en)
      begin
         next_out.p1[5] = ~EXT_BUS_I.wr;
         next_oe.p1[5] = 1'b1;
      end
      if (EXT_BUS_I.access && rd_en)
      begin
         next_out.p1[6] = ~EXT_BUS_I.rd;
         next_oe.p1[6] = 1'b1;
      end
      if (EXT_BUS_I.access && (wr_en || rd_en))
      begin
         next_out.p1[7] = EXT_BUS_I.ale;
         next_oe.p1[7] = 1'b1;
      end

      // port 2 has no direction register: a latch of zero pulls low
      next_out.p2 = port2_out_latch[2:0];
      next_oe.p2 = ~port2_out_latch[2:0];
      if (dual_clock)
      begin
         next_oe.p2[2:1] = 2'h0;
      end

      next_out.p3 = port3_out_latch;
      next_oe.p3 = port3_dir;
      next_out.p3[5] = port3_out_latch[5] & ALT_OUT_I.timer_out_zero;
      next_out.p3[7] = port3_out_latch[7] & ALT_OUT_I.compare_out_zero;
      if (EXT_BUS_I.access && hi_en)
      begin
         next_out.p3 = EXT_BUS_I.addr[15:8];
         next_oe.p3 = 8'hff;
      end

      next_out.p4 = port4_out_latch;
      // open-drain bits only sink, releasing the pin for a one
      next_oe.p4 = port4_dir & (~port4_open_drain_sel | ~port4_out_latch);

      if (!drive_en)
      begin
         next_oe = '0;
      end
      if (stop_mode)
      begin
         next_oe.p2[0] = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         PIN_OUT_O <= '0;
         PIN_OE_O <= '0;
      end
      else
      begin
         PIN_OUT_O <= next_out;
         PIN_OE_O <= next_oe;
      end
   end

   // ----------------------------------------------------------------
   // external bus data, stall input, port 2 bit 0 edge
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         EXT_RDATA_O <= 8'h00;
         BUS_STALL_N_O <= 1'b1;
         // sync stages reset low, so a high here would fake a fall
         p20_prev <= 1'b0;
         PORT2_BIT0_FALL_O <= 1'b0;
         PIN_LEVEL_O <= '0;
      end
      else
      begin
         if (EXT_BUS_I.access && EXT_BUS_I.rd)
         begin
            EXT_RDATA_O <= pin_sync.p0;
         end
         BUS_STALL_N_O <= stall_en ? pin_sync.p1[1] : 1'b1;
         p20_prev <= pin_sync.p2[0];
         // the pin view includes our own drive, so output pulses count too
         PORT2_BIT0_FALL_O <= p20_prev & ~pin_sync.p2[0];
         PIN_LEVEL_O <= pin_sync;
      end
   end

endmodule

// file: bench/mpio_chk.sv
`timescale 1ns/100ps
module mpio_chk
   import mpio_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire mpio_pins_t PIN_IN_I,
   input wire mpio_pins_t PIN_OUT_O,
   input wire mpio_pins_t PIN_OE_O,
   input wire mpio_ext_bus_t EXT_BUS_I,
   input wire logic BUS_STALL_N_O,
   input wire logic PORT2_BIT0_FALL_O,
   input wire mpio_pins_t PIN_LEVEL_O
);
   // ----
   // sync pipeline age, past values before it are reset junk
   // ----
   logic [2:0] age;
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);
   apb_ready_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
      else $error("no ready after setup");
   ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
      else $error("ready without setup");
   err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error outside access");
   rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
      else $error("read data outside access");
   fall_pulse_a: assert property (age > 3'h4 && PORT2_BIT0_FALL_O |->
      $past(PIN_IN_I.p2[0], 3) == 1'b0 && $past(PIN_IN_I.p2[0], 4) == 1'b1)
      else $error("fall pulse without pin fall");
   level_copy_a: assert property (age == 3'h7 |-> PIN_LEVEL_O == $past(PIN_IN_I, 3))
      else $error("pin level view wrong");
   ale_drive_a: assert property ($past(EXT_BUS_I.access && EXT_BUS_I.ale) |->
      PIN_OE_O.p0 == 8'hff && PIN_OUT_O.p0 == $past(EXT_BUS_I.addr[7:0]))
      else $error("low address not driven");
   rd_float_a: assert property
      ($past(EXT_BUS_I.access && EXT_BUS_I.rd && !EXT_BUS_I.ale) |-> PIN_OE_O.p0 == 8'h00)
      else $error("data bus driven in read");
   p2_low_a: assert property ((PIN_OE_O.p2 & PIN_OUT_O.p2) == 3'h0)
      else $error("port 2 drives high");
   rst_idle_a: assert property ($fell(SYS_RST_I) |->
      PIN_OE_O == '0 ##1 (PIN_OE_O == '0 && PIN_OUT_O.p4 == 8'hff))
      else $error("pins not idle after reset");
   stall_pin_a: assert property (!BUS_STALL_N_O |-> !PIN_LEVEL_O.p1[1])
      else $error("stall without low pin");
endmodule

bind mpio_ports mpio_chk mpio_chk_i (.*);

// file: bench/mpio_pin_model.sv
`timescale 1ns/100ps
module mpio_pin_model
   import mpio_pkg::*;
(
   input wire mpio_pins_t pin_out_i,
   input wire mpio_pins_t pin_oe_i,
   input wire mpio_pins_t board_i,
   output mpio_pins_t pin_lvl_o
);
   // released pins show the board level, never the last drive
   assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & board_i);
endmodule

// file: bench/tb_multiplexed_parallel_io_ports.sv
`timescale 1ns/100ps
module tb_multiplexed_parallel_io_ports;
   import mpio_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, stall_n, fall;
   logic strap_n = 1'b1;
   logic mcyc = 1'b0;
   logic [1:0] mc = 2'h0;
   mpio_pins_t pin_in, pin_out, pin_oe;
   mpio_pins_t board = '1;
   mpio_ext_bus_t ebus = '0;
   mpio_alt_out_t alt = '1;
   logic [7:0] ext_rd, bv, wd;
   logic [15:0] a16;
   logic [7:0] dir [5];
   logic [7:0] lat [5];
   logic [6:0] dix [5] = '{7'h08, 7'h09, 7'h00, 7'h0a, 7'h0b};
   logic [6:0] ri [10] = '{7'h02, 7'h04, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h31, 7'h32, 7'h40};
   logic [7:0] rv [10] = '{RST_PORT2_OUT_LATCH, RST_PORT4_OUT_LATCH, RST_DIR, RST_DIR, RST_DIR,
      RST_DIR, RST_PORT4_OPEN_DRAIN_SEL, RST_EXT_BUS_CTRL, RST_BUS_STALL_CTRL, 8'h01};
   int pl [4] = '{0, 1, 3, 4};
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int falls = 0;
   int p, f0, lows;

   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      mc <= mc + 2'h1;
      mcyc <= (mc == 2'h3);
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         err_total++;
         test_done();
      end
   end
   always @(negedge clk)
      if (fall === 1'b1)
         falls++;

   mpio_ports mpio_ports_i (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
      .PIN_OE_O(pin_oe), .EXT_ACCESS_SEL_PIN_N_I(strap_n), .MCYCLE_I(mcyc),
      .EXT_BUS_I(ebus), .ALT_OUT_I(alt), .EXT_RDATA_O(ext_rd), .BUS_STALL_N_O(stall_n),
      .PORT2_BIT0_FALL_O(fall), .PIN_LEVEL_O());
   mpio_pin_model mpio_pin_model_i (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .board_i(board),
      .pin_lvl_o(pin_in));

   // ----
   // bus, board and compare helpers
   // ----
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // waits on ready with no cycle count assumed; the global timeout cuts a hang
   task apb(input logic w, input logic [6:0] idx, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {3'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task setb(input int q, input logic [7:0] v);
      @(posedge clk);
      case (q)
         0: board.p0 <= v;
         1: board.p1 <= v;
         2: board.p2 <= v[2:0];
         3: board.p3 <= v;
         default: board.p4 <= v;
      endcase
   endtask
   task settle();
      repeat (6) @(negedge clk);
   endtask
   function automatic logic [7:0] sl(mpio_pins_t v, int q);
      case (q)
         0: return v.p0;
         1: return v.p1;
         3: return v.p3;
         default: return v.p4;
      endcase
   endfunction
   function automatic logic [7:0] am(int q);
      if (q == 1)
         return {3'h7, alt.timer_out_one, alt.divider_out, 3'h7};
      if (q == 3)
         return {alt.compare_out_zero, 1'b1, alt.timer_out_zero, 5'h1f};
      return 8'hff;
   endfunction
   task test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----
   // main sequence
   // ----
   initial
   begin
      void'($urandom(32'hf550a0f2));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      chk(pin_oe, '0);
      chk(pin_out, {8'hff, 8'h00, 3'h7, 8'h00, 8'h00});
      for (int i = 0; i < 10; i++)
      begin
         apb(1'b0, ri[i], 8'h00);
         chk(rd, {24'h0, rv[i]});
      end
      $display("done: reset values");
      for (int k = 0; k < 24; k++)
      begin
         p = pl[k % 4];
         dir[p] = $urandom;
         lat[p] = $urandom | (p == 1 ? 8'h18 : p == 3 ? 8'ha0 : 8'h00);
         bv = $urandom;
         apb(1'b1, p[6:0], lat[p]);
         apb(1'b1, dix[p], dir[p]);
         @(posedge clk);
         alt <= mpio_alt_out_t'($urandom);
         setb(p, bv);
         settle();
         chk(sl(pin_oe, p), dir[p]);
         chk(sl(pin_out, p), lat[p] & am(p));
         apb(1'b0, p[6:0], 8'h00);
         chk(rd, p == 4 ? lat[p] : (dir[p] & lat[p]) | (~dir[p] & bv));
         if (p == 4)
         begin
            apb(1'b0, IDX_PORT4_PIN_IN, 8'h00);
            chk(rd, (dir[p] & lat[p]) | (~dir[p] & bv));
         end
      end
      wd = $urandom;
      apb(1'b1, IDX_PORT4_OPEN_DRAIN_SEL, wd);
      apb(1'b0, IDX_PORT4_OPEN_DRAIN_SEL, 8'h00);
      chk(rd, wd);
      // a plain write, never read-modify-write, to clear a control register
      apb(1'b1, IDX_PORT4_OPEN_DRAIN_SEL, 8'h00);
      $display("done: port traffic");
      setb(2, 8'hff);
      apb(1'b1, IDX_PORT2_OUT_LATCH, 8'hfe);
      f0 = falls;
      settle();
      chk(pin_oe.p2, 3'h1);
      chk(falls - f0, 1);
      apb(1'b0, IDX_PORT2_PIN_IN, 8'h00);
      chk(rd, 32'h6);
      apb(1'b0, IDX_PORT2_OUT_LATCH, 8'h00);
      chk(rd, 32'hfe);
      apb(1'b1, IDX_PORT_MODE_CTRL, 8'h03);
      settle();
      chk(pin_oe.p2, 3'h0);
      apb(1'b1, IDX_PORT_MODE_CTRL, 8'h01);
      apb(1'b1, IDX_PORT2_OUT_LATCH, 8'hf9);
      settle();
      chk(pin_oe.p2, 3'h6);
      apb(1'b1, IDX_PORT_MODE_CTRL, 8'h05);
      settle();
      chk(pin_oe.p2, 3'h0);
      apb(1'b1, IDX_PORT_MODE_CTRL, 8'h01);
      apb(1'b1, IDX_PORT2_OUT_LATCH, 8'hff);
      apb(1'b0, 7'h05, 8'h00);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, IDX_PORT2_PIN_IN, 8'h00);
      chk(err, 1'b1);
      $display("done: port 2 and refusals");
      apb(1'b1, IDX_EXT_BUS_CTRL, 8'h07);
      a16 = $urandom;
      wd = $urandom;
      bv = $urandom;
      @(posedge clk);
      ebus <= '{1'b1, 1'b1, 1'b0, 1'b1, a16, wd};
      settle();
      chk({pin_oe.p0, pin_out.p0, pin_oe.p3, pin_out.p3}, {8'hff, a16[7:0], 8'hff, a16[15:8]});
      chk({pin_out.p1[7:5], pin_oe.p1[7:5]}, 6'b110111);
      setb(0, bv);
      ebus <= '{1'b1, 1'b0, 1'b1, 1'b0, a16, wd};
      settle();
      chk({pin_oe.p0, ext_rd, pin_out.p1[7:5]}, {8'h00, bv, 3'b001});
      @(posedge clk);
      ebus <= '{1'b1, 1'b0, 1'b0, 1'b1, a16, wd};
      settle();
      chk({pin_oe.p0, pin_out.p0}, {8'hff, wd});
      @(posedge clk);
      ebus <= '0;
      apb(1'b1, IDX_EXT_BUS_CTRL, 8'h00);
      apb(1'b1, IDX_PORT1_DIR, 8'h00);
      apb(1'b1, IDX_BUS_STALL_CTRL, 8'hc0);
      setb(1, 8'hfd);
      settle();
      chk({stall_n, pin_oe.p1[1]}, 2'b00);
      setb(1, 8'hff);
      settle();
      chk(stall_n, 1'b1);
      apb(1'b1, IDX_BUS_STALL_CTRL, 8'h00);
      $display("done: external bus");
      @(posedge clk);
      strap_n <= 1'b0;
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(negedge clk);
      lows = 0;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         lows += (pin_out.p1[0] === 1'b0);
      end
      chk({lows[3:0], pin_oe.p1[0]}, 5'h5);
      apb(1'b0, IDX_PORT_MODE_CTRL, 8'h00);
      chk(rd[MODE_CLOCK_OUT_ACTIVE_BIT], 1'b1);
      $display("done: clock strap");
      test_done();
   end
endmodule
